// ### rtl/mcss_pkg.sv
// package: register map, field layout, reset values and codes of the clock source setup
package mcss_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address on the bus is four times the index
  localparam logic [19:0] MCSS_IDX_OPT_BYTE = 20'h000C2; // frequency / flash option byte
  localparam logic [19:0] MCSS_IDX_PIN_MODE = 20'hFFFA0; // clock_pin_mode_control
  localparam logic [19:0] MCSS_IDX_RUN_CTRL = 20'hFFFA1; // oscillator_run_control
  localparam logic [19:0] MCSS_IDX_STATUS = 20'hFFFA2; // decoded state readback

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int MCSS_OPT_MODE_HI = 7; // flash_mode_sel_hi
  localparam int MCSS_OPT_MODE_LO = 6; // flash_mode_sel_lo
  localparam int MCSS_OPT_FREQ_MSB = 3; // internal_osc_freq_sel msb
  localparam int MCSS_PIN_EXT = 7; // ext_clock_pin_sel
  localparam int MCSS_PIN_RES = 6; // resonator_pin_sel
  localparam int MCSS_PIN_AMP = 0; // oscillator amplitude gain select
  localparam int MCSS_RUN_EXT_HALT = 7; // external_osc_halt
  localparam int MCSS_RUN_FIXED_ONE = 6; // reads as one
  localparam int MCSS_RUN_INT_HALT = 0; // internal_osc_halt

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] MCSS_PIN_MODE_RST = 8'h00;
  localparam logic [7:0] MCSS_RUN_CTRL_RST = 8'hC0;

  ////////////////////////////////////////////////////////////////////////////////
  // frequency codes and results in MHz
  localparam logic [3:0] MCSS_FRQ_32 = 4'h8;
  localparam logic [3:0] MCSS_FRQ_24 = 4'h0;
  localparam logic [3:0] MCSS_FRQ_1 = 4'hD;
  localparam logic [5:0] MCSS_MHZ_32 = 6'h20;
  localparam logic [5:0] MCSS_MHZ_24 = 6'h18;
  localparam logic [5:0] MCSS_MHZ_1 = 6'h01;
  localparam logic [5:0] MCSS_MHZ_NONE = 6'h00;

  // upper frequency limits per flash mode
  localparam logic [5:0] MCSS_LIM_LV = 6'h04;
  localparam logic [5:0] MCSS_LIM_LS = 6'h08;
  localparam logic [5:0] MCSS_LIM_HS = 6'h20;

  ////////////////////////////////////////////////////////////////////////////////
  // flash mode encodings
  typedef enum logic [1:0] {
    MCSS_LOW_VOLTAGE_FLASH_MODE = 2'h0,
    MCSS_PROHIBITED_FLASH_MODE = 2'h1,
    MCSS_LOW_SPEED_FLASH_MODE = 2'h2,
    MCSS_HIGH_SPEED_FLASH_MODE = 2'h3
  } mcss_flash_mode_t;

  // clock pin modes (ext_clock_pin_sel, resonator_pin_sel)
  localparam logic [1:0] MCSS_PM_PORT0 = 2'h0;
  localparam logic [1:0] MCSS_PM_RES = 2'h1;
  localparam logic [1:0] MCSS_PM_PORT1 = 2'h2;
  localparam logic [1:0] MCSS_PM_EXT = 2'h3;

  // control phases, one-hot
  typedef enum logic [1:0] {
    MCSS_ST_CAPTURE = 2'h1,
    MCSS_ST_RUN = 2'h2
  } mcss_phase_t;

  ////////////////////////////////////////////////////////////////////////////////
  // classic wishbone request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [21:0] adr;
    logic [31:0] dat;
  } mcss_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mcss_wb_rsp_t;

  // whole state of the controller
  typedef struct packed {
    mcss_phase_t phase;
    logic [7:0] opt;
    logic [7:0] pin_mode;
    logic ext_halt;
    logic int_halt;
    logic ack;
    logic [31:0] rdata;
  } mcss_state_t;

endpackage : mcss_pkg

// ### rtl/mcss_sync.sv
// two flip-flop synchroniser for levels entering from outside the clock domain
module mcss_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk_i,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q; // first stage, read only by the second
  logic [W-1:0] sync_q; // second stage

  // two stages, no reset so the chain fills while reset is held
  always_ff @(posedge clk_i)
  begin
    meta_q <= d_i;
    sync_q <= meta_q;
  end

  assign q_o = sync_q;

endmodule : mcss_sync

// ### rtl/mcss_top.sv
// main clock source setup: option byte capture, pin mode and oscillator run control
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - frequency code gives 32, 24 or 1 MHz
// - flash mode code selects LV, LS or HS
// - pin mode bits set port/resonator/external clock
// - external halt bit stops oscillator or clock
// - internal halt bit stops on-chip oscillator
//
// Design decision made here: the Wishbone register port.
module mcss_top
  import mcss_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire mcss_wb_req_t wb_req_i,
  output mcss_wb_rsp_t wb_rsp_o,
  // non-volatile option byte and clock pins
  input wire logic [7:0] opt_byte_i,
  input wire logic resonator_pin_a_i,
  input wire logic resonator_pin_b_i,
  // decoded configuration
  output logic [5:0] osc_freq_mhz_o,
  output mcss_flash_mode_t flash_mode_o,
  output logic cfg_valid_o,
  output logic freq_in_range_o,
  // pin and oscillator control
  output logic pin_a_port_en_o,
  output logic pin_b_port_en_o,
  output logic resonator_en_o,
  output logic ext_clk_in_en_o,
  output logic xtal_osc_run_o,
  output logic ext_clk_accept_o,
  output logic ext_clk_o,
  output logic int_osc_run_o,
  output logic [1:0] port_data_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // frequency code to MHz, zero for a prohibited code
  function automatic logic [5:0] mcss_freq_mhz(input logic [3:0] code);
    case (code)
      MCSS_FRQ_32: mcss_freq_mhz = MCSS_MHZ_32;
      MCSS_FRQ_24: mcss_freq_mhz = MCSS_MHZ_24;
      MCSS_FRQ_1: mcss_freq_mhz = MCSS_MHZ_1;
      default: mcss_freq_mhz = MCSS_MHZ_NONE;
    endcase
  endfunction : mcss_freq_mhz

  // upper limit of a flash mode, zero when prohibited
  function automatic logic [5:0] mcss_mode_lim(input logic [1:0] mode);
    case (mode)
      MCSS_LOW_VOLTAGE_FLASH_MODE: mcss_mode_lim = MCSS_LIM_LV;
      MCSS_LOW_SPEED_FLASH_MODE: mcss_mode_lim = MCSS_LIM_LS;
      MCSS_HIGH_SPEED_FLASH_MODE: mcss_mode_lim = MCSS_LIM_HS;
      default: mcss_mode_lim = MCSS_MHZ_NONE;
    endcase
  endfunction : mcss_mode_lim

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers for outside levels

  logic [7:0] opt_sync; // option byte after two flops
  logic [1:0] pin_sync; // clock pins after two flops

  mcss_sync #(.W(8)) u_opt_sync (
    .clk_i(clk_i),
    .d_i(opt_byte_i),
    .q_o(opt_sync)
  );

  mcss_sync #(.W(2)) u_pin_sync (
    .clk_i(clk_i),
    .d_i({resonator_pin_b_i, resonator_pin_a_i}),
    .q_o(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // state and decode

  mcss_state_t s_q; // registered state
  mcss_state_t s_d; // next state
  logic [5:0] mhz; // decoded frequency
  logic [5:0] lim; // limit of the selected mode
  logic [1:0] mode; // flash mode bits
  logic [1:0] pmode; // pin mode bits
  logic req; // bus request held, cyc and stb
  logic [19:0] idx; // register index from address
  logic [7:0] status; // readback of decoded state

  assign mode = {s_q.opt[MCSS_OPT_MODE_HI], s_q.opt[MCSS_OPT_MODE_LO]};
  assign mhz = mcss_freq_mhz(s_q.opt[MCSS_OPT_FREQ_MSB -: 4]);
  assign lim = mcss_mode_lim(mode);
  assign pmode = {s_q.pin_mode[MCSS_PIN_EXT], s_q.pin_mode[MCSS_PIN_RES]};
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign idx = wb_req_i.adr[21:2];
  assign status = {2'h0, int_osc_run_o, ext_clk_accept_o, xtal_osc_run_o,
                   freq_in_range_o, mode != MCSS_PROHIBITED_FLASH_MODE, mhz != MCSS_MHZ_NONE};

  // next-state logic: capture phase, bus reads and writes
  always_comb
  begin
    s_d = s_q;
    s_d.ack = req & ~s_q.ack; // answer one cycle after the request
    // option byte taken once, in the first cycle after reset
    case (s_q.phase)
      MCSS_ST_CAPTURE:
      begin
        s_d.opt = opt_sync;
        s_d.phase = MCSS_ST_RUN;
      end
      MCSS_ST_RUN: s_d.opt = s_q.opt;
      default: s_d.phase = MCSS_ST_CAPTURE;
    endcase
    // read data loaded so it is valid with ack
    if (req & ~s_q.ack)
    begin
      case (idx)
        MCSS_IDX_OPT_BYTE: s_d.rdata = {24'h000000, s_q.opt};
        MCSS_IDX_PIN_MODE: s_d.rdata = {24'h000000, s_q.pin_mode};
        MCSS_IDX_RUN_CTRL:
          s_d.rdata = {24'h000000, s_q.ext_halt, 1'b1, 5'h00, s_q.int_halt};
        MCSS_IDX_STATUS: s_d.rdata = {24'h000000, status};
        default: s_d.rdata = 32'h00000000; // unmapped reads zero
      endcase
    end
    // a write takes effect at the edge where ack is seen
    if (req & s_q.ack & wb_req_i.we & wb_req_i.sel[0])
    begin
      case (idx)
        MCSS_IDX_PIN_MODE:
        begin
          s_d.pin_mode = 8'h00;
          s_d.pin_mode[MCSS_PIN_EXT] = wb_req_i.dat[MCSS_PIN_EXT];
          s_d.pin_mode[MCSS_PIN_RES] = wb_req_i.dat[MCSS_PIN_RES];
          s_d.pin_mode[MCSS_PIN_AMP] = wb_req_i.dat[MCSS_PIN_AMP];
        end
        MCSS_IDX_RUN_CTRL:
        begin
          s_d.ext_halt = wb_req_i.dat[MCSS_RUN_EXT_HALT];
          s_d.int_halt = wb_req_i.dat[MCSS_RUN_INT_HALT];
        end
        default: s_d.ack = s_d.ack; // read-only or unmapped: ignored
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q.phase <= MCSS_ST_CAPTURE;
      s_q.opt <= 8'h00;
      s_q.pin_mode <= MCSS_PIN_MODE_RST;
      s_q.ext_halt <= MCSS_RUN_CTRL_RST[MCSS_RUN_EXT_HALT];
      s_q.int_halt <= MCSS_RUN_CTRL_RST[MCSS_RUN_INT_HALT];
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h00000000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_rsp_o.ack = s_q.ack;
  assign wb_rsp_o.dat = s_q.rdata;
  assign osc_freq_mhz_o = mhz;
  assign flash_mode_o = mcss_flash_mode_t'(mode);
  assign cfg_valid_o = (mhz != MCSS_MHZ_NONE) & (mode != MCSS_PROHIBITED_FLASH_MODE);
  assign freq_in_range_o = cfg_valid_o & (mhz <= lim); // high when the configuration is valid and the frequency is within the mode limit
  // pin roles from the pin mode bits
  assign resonator_en_o = (pmode == MCSS_PM_RES);
  assign ext_clk_in_en_o = (pmode == MCSS_PM_EXT);
  assign pin_a_port_en_o = ~resonator_en_o;
  assign pin_b_port_en_o = (pmode == MCSS_PM_PORT0) | (pmode == MCSS_PM_PORT1);
  // oscillator run controls
  assign xtal_osc_run_o = resonator_en_o & ~s_q.ext_halt;
  assign ext_clk_accept_o = ext_clk_in_en_o & ~s_q.ext_halt;
  assign ext_clk_o = ext_clk_accept_o & pin_sync[1];
  assign int_osc_run_o = ~s_q.int_halt;
  assign port_data_o = {pin_sync[1] & pin_b_port_en_o, pin_sync[0] & pin_a_port_en_o};

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_captured;
    s_q.phase == MCSS_ST_RUN;
  endsequence

  property p_opt_held;
    @(posedge clk_i) disable iff (rst_i) s_captured ##1 1'b1 |-> $stable(s_q.opt);
  endproperty
  a_opt_held: assert property (p_opt_held) else $error("option byte changed");

  property p_capture_once;
    @(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> ##1 s_q.phase == MCSS_ST_RUN;
  endproperty
  a_capture_once: assert property (p_capture_once) else $error("no capture");

  property p_freq32;
    @(posedge clk_i) disable iff (rst_i)
      s_q.opt[3:0] == MCSS_FRQ_32 |-> osc_freq_mhz_o == 6'h20;
  endproperty
  a_freq32: assert property (p_freq32) else $error("32 MHz decode wrong");

  property p_mode_invalid;
    @(posedge clk_i) disable iff (rst_i) s_q.opt[7:6] == 2'h1 |-> !cfg_valid_o;
  endproperty
  a_mode_invalid: assert property (p_mode_invalid) else $error("bad mode accepted");

  property p_res_pins;
    @(posedge clk_i) disable iff (rst_i)
      resonator_en_o |-> !pin_a_port_en_o && !pin_b_port_en_o && !ext_clk_in_en_o;
  endproperty
  a_res_pins: assert property (p_res_pins) else $error("resonator pin roles");

  property p_ext_halt;
    @(posedge clk_i) disable iff (rst_i)
      req && s_q.ack && wb_req_i.we && wb_req_i.sel[0] && idx == MCSS_IDX_RUN_CTRL
      && wb_req_i.dat[7] |=> !xtal_osc_run_o && !ext_clk_accept_o;
  endproperty
  a_ext_halt: assert property (p_ext_halt) else $error("external halt ignored");

  property p_int_halt;
    @(posedge clk_i) disable iff (rst_i)
      req && s_q.ack && wb_req_i.we && wb_req_i.sel[0] && idx == MCSS_IDX_RUN_CTRL
      |=> int_osc_run_o == !$past(wb_req_i.dat[0]);
  endproperty
  a_int_halt: assert property (p_int_halt) else $error("internal halt wrong");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) req && !s_q.ack |=> s_q.ack ##1 !s_q.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");

endmodule : mcss_top

// ### testbench/mcss_clk_src.sv
// far-side model: resonator pair or external clock source on the two clock pins
module mcss_clk_src
(
  // model clock
  input wire logic clk_i,
  // pin mode seen from the device
  input wire logic res_en_i,
  input wire logic ext_en_i,
  // clock pin levels
  output logic pin_a_o,
  output logic pin_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q = 2'h0; // quarter-rate phase
  ////////////////////////////////////////////////////////////////////////////////
  // free-running phase divider
  always @(posedge clk_i)
  begin
    div_q <= div_q + 2'h1;
  end
  // pin levels per mode; port use shows a=1, b=0
  always_comb
  begin
    pin_a_o = 1'b1;
    pin_b_o = 1'b0;
    if (ext_en_i)
    begin
      pin_b_o = div_q[1]; // external clock on pin b
    end
    else if (res_en_i)
    begin
      pin_a_o = div_q[1]; // resonator swing
      pin_b_o = ~div_q[1];
    end
  end
endmodule : mcss_clk_src

// ### testbench/mcss_top_tb.sv
// testbench of the main clock source setup block
module mcss_top_tb
  import mcss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [21:0] PM = 22'h3FFE80; // pin mode
  localparam logic [21:0] RC = 22'h3FFE84; // run control
  // option byte, then {freq, mode, valid, in range}
  localparam logic [17:0] OPT_TAB [6] = '{{8'hE8, 6'h20, 2'h3, 2'h3},
    {8'hC0, 6'h18, 2'h3, 2'h3}, {8'h0D, 6'h01, 2'h0, 2'h3}, {8'h88, 6'h20, 2'h2, 2'h2},
    {8'h4D, 6'h01, 2'h1, 2'h0}, {8'hE1, 6'h00, 2'h3, 2'h0}};
  localparam logic [3:0] PIN_EXP [4] = '{4'hC, 4'h2, 4'hC, 4'h9}; // port a/b, res, ext
  localparam logic [1:0] PORT_EXP [4] = '{2'h1, 2'h0, 2'h1, 2'h1};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mcss_wb_req_t wb_req = '0;
  mcss_wb_rsp_t wb_rsp;
  logic [7:0] opt_byte = 8'hE8; // application setting
  logic pin_a, pin_b, cfg_valid, in_range, pa_en, pb_en, res_en, ext_en;
  logic xtal_run, ext_acc, ext_clk, int_run;
  logic [5:0] freq;
  mcss_flash_mode_t fmode;
  logic [1:0] port_data;
  logic [31:0] rd;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  // device and far side
  mcss_top mcss_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .opt_byte_i(opt_byte), .resonator_pin_a_i(pin_a), .resonator_pin_b_i(pin_b),
    .osc_freq_mhz_o(freq), .flash_mode_o(fmode), .cfg_valid_o(cfg_valid),
    .freq_in_range_o(in_range), .pin_a_port_en_o(pa_en), .pin_b_port_en_o(pb_en),
    .resonator_en_o(res_en), .ext_clk_in_en_o(ext_en), .xtal_osc_run_o(xtal_run),
    .ext_clk_accept_o(ext_acc), .ext_clk_o(ext_clk), .int_osc_run_o(int_run),
    .port_data_o(port_data));
  mcss_clk_src mcss_clk_src_inst (.clk_i(clk_i), .res_en_i(res_en), .ext_en_i(ext_en),
    .pin_a_o(pin_a), .pin_b_o(pin_b));
  ////////////////////////////////////////////////////////////////////////////////
  // compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // one classic wishbone cycle, lane 0
  task automatic wb(input logic w, input logic [21:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a, dat: {24'h0, d}};
    // hold the request until ack is sampled high at a rising edge
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_rsp.ack !== 1'b1 && k < 64);
    if (wb_rsp.ack !== 1'b1)
      mismatches++;
    // read data taken and request released at the ack edge
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb
  // 16-cycle reset, settle after release
  task automatic rst_seq();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask : rst_seq
  // rising edges of the gated external clock over 32 cycles
  task automatic cnt_edges(output int c);
    logic prev;
    c = 0;
    prev = ext_clk;
    repeat (32)
    begin
      @(negedge clk_i);
      if (ext_clk === 1'b1 && prev !== 1'b1)
        c++;
      prev = ext_clk;
    end
  endtask : cnt_edges
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #100us;
    mismatches++;
    conclude();
  end
  // test sequence
  initial
  begin
    rst_seq();
    wb(1'b0, PM, 8'h00, rd);
    chk(rd, 32'h00);
    wb(1'b0, RC, 8'h00, rd);
    chk(rd, 32'hC0);
    chk(32'(int_run), 32'h1);
    wb(1'b0, 22'h3FFE88, 8'h00, rd);
    chk(rd, 32'h27);
    wb(1'b1, 22'h000308, 8'h00, rd);
    wb(1'b0, 22'h000308, 8'h00, rd);
    chk(rd, 32'hE8);
    wb(1'b0, 22'h000100, 8'h00, rd);
    chk(rd, 32'h00);
    wb(1'b1, PM, 8'hFF, rd);
    wb(1'b0, PM, 8'h00, rd);
    chk(rd, 32'hC1);
    wb(1'b1, RC, 8'h3F, rd);
    wb(1'b0, RC, 8'h00, rd);
    chk(rd, 32'h41);
    chk(32'(int_run), 32'h0);
    $display("test registers done");
    // every pin mode with the external halt cleared
    wb(1'b1, RC, 8'h40, rd);
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, PM, {m[1:0], 6'h00}, rd);
      repeat (3) @(negedge clk_i);
      chk(32'({pa_en, pb_en, res_en, ext_en}), 32'(PIN_EXP[m]));
      chk(32'(port_data), 32'(PORT_EXP[m]));
      chk(32'({xtal_run, ext_acc}), 32'({m == 1, m == 3}));
    end
    cnt_edges(n);
    chk(32'(n > 0), 32'h1);
    wb(1'b1, RC, 8'hC0, rd);
    repeat (4) @(negedge clk_i);
    cnt_edges(n);
    chk(32'({n > 0, ext_acc, int_run}), 32'h1);
    $display("test pin modes done");
    // option byte codes, captured once per reset
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i);
      opt_byte <= OPT_TAB[i][17:10];
      rst_seq();
      chk(32'({freq, fmode, cfg_valid, in_range}), 32'(OPT_TAB[i][9:0]));
      @(posedge clk_i);
      opt_byte <= ~OPT_TAB[i][17:10];
      repeat (8) @(negedge clk_i);
      chk(32'({freq, fmode, cfg_valid, in_range}), 32'(OPT_TAB[i][9:0]));
    end
    $display("test option byte done");
    conclude();
  end
endmodule : mcss_top_tb
